// *** core/pslo_pkg.sv ***
/*
 * constants, types and timing figures for the phy startup sequencer and
 * loss-of-signal output block.
 * assumes the reference clock runs at 20 MHz (50 ns period).
 */
package pslo_pkg;

   // reference clock
   localparam int unsigned CLK_PERIOD_NS = 50;

   // startup and pulse times in their own units, as printed
   localparam int unsigned REF_SETTLE_MS = 11;
   localparam int unsigned PLL_LOCK_US = 50;
   localparam int unsigned ADC_CAL_US = 2050;
   localparam int unsigned LOS_SHORT_MS = 20;
   localparam int unsigned LOS_MID_MS = 200;
   localparam int unsigned LOS_LONG_MS = 500;

   // least times round up to whole cycles
   localparam int unsigned REF_SETTLE_CYC =
      (REF_SETTLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PLL_LOCK_CYC =
      (PLL_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned ADC_CAL_CYC =
      (ADC_CAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LOS_SHORT_CYC =
      (LOS_SHORT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LOS_MID_CYC =
      (LOS_MID_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LOS_LONG_CYC =
      (LOS_LONG_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // counter width: 500 ms is 10,000,000 cycles
   localparam int unsigned CNT_W = 24;

   // management register map
   localparam logic [4:0] LOS_CTRL_ADDR = 5'h1E;
   localparam logic [15:0] LOS_CTRL_RESET = 16'h0001;
   localparam int unsigned LOS_MODE_LSB = 0;

   // loss-of-signal behaviour field
   localparam logic [1:0] LOS_MODE_OFF = 2'h0;
   localparam logic [1:0] LOS_MODE_SHORT = 2'h1;
   localparam logic [1:0] LOS_MODE_MID = 2'h2;
   localparam logic [1:0] LOS_MODE_LONG = 2'h3;

   typedef enum logic [2:0] {
      ST_CAPTURE = 3'b000,
      ST_REF_SETTLE = 3'b001,
      ST_PLL_LOCK = 3'b010,
      ST_ADC_CAL = 3'b011,
      ST_RUN = 3'b100
   } pslo_state_t;

   typedef struct packed {
      logic pll_source_strap;
      logic eeprom_data_strap;
      logic module_mode_strap_bit;
   } pslo_straps_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [4:0] addr;
      logic [15:0] wdata;
   } pslo_mgmt_req_t;

endpackage

// *** core/pslo_startup.sv ***
/*
 * phy startup sequencer with the programmable loss-of-signal output for
 * pluggable-module mode, plus the management-side loss control register.
 * assumes: core_clk is the 20 MHz reference clock; straps are board pins;
 * link status, eeprom script completion and management requests come from
 * logic on core_clk.
 */
// Functional notes
// RULE_01 - strap bit zero selects module mode; shared pin then carries loss-of-signal
// RULE_02 - loss-of-signal is active high, raised when the media link drops
// RULE_03 - behaviour chosen by bits 1:0 of management register 30
// RULE_04 - field 00 keeps loss-of-signal low always
// RULE_05 - field 01 gives one 20 ms pulse per link-down
// RULE_06 - field 10 gives one 200 ms pulse per link-down
// RULE_07 - field 11 gives one 500 ms pulse per link-down
// RULE_08 - pll, eeprom and mode straps latched at reset release
// RULE_09 - without eeprom, management interface active at first edge after release
// RULE_10 - with eeprom, management interface waits for script completion
// RULE_11 - wait about 11 ms for references to settle
// RULE_12 - then wait 50 us for pll lock
// RULE_13 - then run 2.05 ms converter calibration
// RULE_14 - clock outputs enabled only after calibration finishes
// RULE_15 - system gives a real rising reset edge after supplies settle
// RULE_16 - host may program registers before full operation
// RULE_17 - all times counted on reference clock; link-down mid-pulse ignored
`timescale 1ns/1ns

module pslo_startup #(
   parameter int unsigned REF_SETTLE_CYCLES = pslo_pkg::REF_SETTLE_CYC,
   parameter int unsigned ADC_CAL_CYCLES = pslo_pkg::ADC_CAL_CYC,
   parameter int unsigned LOS_SHORT_CYCLES = pslo_pkg::LOS_SHORT_CYC,
   parameter int unsigned LOS_MID_CYCLES = pslo_pkg::LOS_MID_CYC,
   parameter int unsigned LOS_LONG_CYCLES = pslo_pkg::LOS_LONG_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // strap pins
   input wire logic pll_source_strap,
   input wire logic eeprom_data_strap,
   input wire logic module_mode_strap_bit,
   // on-chip status
   input wire logic media_link_up,
   input wire logic eeprom_script_done,
   // management register access
   input wire pslo_pkg::pslo_mgmt_req_t mgmt_req,
   output logic [15:0] mgmt_rdata,
   output logic mgmt_rvalid,
   // startup status
   output logic mgmt_active,
   output logic clk_out_enable,
   output logic pll_source_latched,
   output logic module_mode,
   // shared loss-of-signal / signal-detect pin
   output logic shared_los_pin
);

   localparam int unsigned W = pslo_pkg::CNT_W;

   // strap synchronisers carry no reset so their pre-release value is
   // already settled at the first edge after reset goes high
   pslo_pkg::pslo_straps_t strap_meta;
   pslo_pkg::pslo_straps_t strap_sync;
   pslo_pkg::pslo_straps_t strap_reg;
   pslo_pkg::pslo_straps_t strap_next;
   // module mode held in its own flop so the output needs no inverter
   logic mode_reg;
   pslo_pkg::pslo_state_t state_reg;
   pslo_pkg::pslo_state_t state_next;
   logic [W-1:0] seq_cnt_reg;
   logic [W-1:0] seq_cnt_next;
   logic smi_reg;
   logic smi_next;
   logic clk_en_reg;
   logic clk_en_next;
   logic [15:0] los_ctrl_reg;
   logic [15:0] los_ctrl_next;
   logic [15:0] rdata_reg;
   logic [15:0] rdata_next;
   logic rvalid_reg;
   logic link_prev_reg;
   logic los_active_reg;
   logic los_active_next;
   logic [W-1:0] los_cnt_reg;
   logic [W-1:0] los_cnt_next;
   logic pin_reg;
   logic pin_next;

   wire logic in_module_mode = mode_reg; // RULE_01
   wire logic [1:0] los_mode = los_ctrl_reg[pslo_pkg::LOS_MODE_LSB +: 2]; // RULE_03
   wire logic link_down = link_prev_reg & ~media_link_up; // RULE_02
   wire logic addr_hit = mgmt_req.addr == pslo_pkg::LOS_CTRL_ADDR;
   wire logic reg_write = mgmt_req.valid & mgmt_req.write & smi_reg & addr_hit;
   wire logic reg_read = mgmt_req.valid & ~mgmt_req.write & smi_reg;
   wire logic ref_done = seq_cnt_reg == W'(REF_SETTLE_CYCLES - 1); // RULE_11
   wire logic pll_done = seq_cnt_reg == W'(pslo_pkg::PLL_LOCK_CYC - 1); // RULE_12
   wire logic cal_done = seq_cnt_reg == W'(ADC_CAL_CYCLES - 1); // RULE_13
   wire logic [W-1:0] los_len =
      (los_mode == pslo_pkg::LOS_MODE_SHORT) ? W'(LOS_SHORT_CYCLES) : // RULE_05
      (los_mode == pslo_pkg::LOS_MODE_MID) ? W'(LOS_MID_CYCLES) : // RULE_06
      W'(LOS_LONG_CYCLES); // RULE_07

   always_ff @(posedge core_clk) begin
      strap_meta <= {pll_source_strap, eeprom_data_strap, module_mode_strap_bit};
      strap_sync <= strap_meta;
   end

   // startup sequence
   always_comb begin
      state_next = state_reg;
      seq_cnt_next = seq_cnt_reg + W'(1);
      strap_next = strap_reg;
      clk_en_next = clk_en_reg;
      if (state_reg == pslo_pkg::ST_CAPTURE) begin
         smi_next = ~strap_sync.eeprom_data_strap; // RULE_09
      end else begin
         // latch once the loader reports the script applied
         smi_next = smi_reg | eeprom_script_done; // RULE_10
      end
      unique case (state_reg)
         pslo_pkg::ST_CAPTURE: begin
            strap_next = strap_sync; // RULE_08
            seq_cnt_next = '0;
            state_next = pslo_pkg::ST_REF_SETTLE;
         end
         pslo_pkg::ST_REF_SETTLE: begin
            if (ref_done) begin
               seq_cnt_next = '0;
               state_next = pslo_pkg::ST_PLL_LOCK; // RULE_11
            end
         end
         pslo_pkg::ST_PLL_LOCK: begin
            if (pll_done) begin
               seq_cnt_next = '0;
               state_next = pslo_pkg::ST_ADC_CAL; // RULE_12
            end
         end
         pslo_pkg::ST_ADC_CAL: begin
            if (cal_done) begin
               seq_cnt_next = '0;
               clk_en_next = 1'b1; // RULE_14
               state_next = pslo_pkg::ST_RUN; // RULE_13
            end
         end
         pslo_pkg::ST_RUN: begin
            seq_cnt_next = '0;
         end
         default: begin
            seq_cnt_next = '0;
            state_next = pslo_pkg::ST_CAPTURE;
         end
      endcase
   end

   // counters run only on core_clk, so all durations follow the reference
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= pslo_pkg::ST_CAPTURE;
         seq_cnt_reg <= '0;
         strap_reg <= '0;
         mode_reg <= 1'b1;
         smi_reg <= 1'b0;
         clk_en_reg <= 1'b0;
      end else begin
         state_reg <= state_next; // RULE_17
         seq_cnt_reg <= seq_cnt_next;
         strap_reg <= strap_next;
         mode_reg <= ~strap_next.module_mode_strap_bit; // RULE_01
         smi_reg <= smi_next;
         clk_en_reg <= clk_en_next;
      end
   end

   // management register; writes ahead of clock enable let the host
   // configure the part before the analog side is up
   always_comb begin
      los_ctrl_next = los_ctrl_reg;
      if (reg_write) begin
         los_ctrl_next = mgmt_req.wdata;
      end
      rdata_next = rdata_reg;
      if (reg_read) begin
         rdata_next = addr_hit ? los_ctrl_reg : 16'h0000;
      end
   end

   // loss-of-signal pulse
   always_comb begin
      los_active_next = los_active_reg;
      los_cnt_next = los_cnt_reg;
      if (los_mode == pslo_pkg::LOS_MODE_OFF) begin
         los_active_next = 1'b0; // RULE_04
         los_cnt_next = '0;
      end else if (los_active_reg) begin
         // further drops are ignored so a flapping link cannot stretch it
         if (los_cnt_reg == W'(1)) begin
            los_active_next = 1'b0; // RULE_17
         end
         los_cnt_next = los_cnt_reg - W'(1);
      end else if (link_down && in_module_mode) begin
         los_active_next = 1'b1; // RULE_02
         los_cnt_next = los_len;
      end
      // outside module mode the pin reports signal detect
      pin_next = in_module_mode ? los_active_next : media_link_up; // RULE_01
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         los_ctrl_reg <= pslo_pkg::LOS_CTRL_RESET;
         rdata_reg <= 16'h0000;
         rvalid_reg <= 1'b0;
         link_prev_reg <= 1'b0;
         los_active_reg <= 1'b0;
         los_cnt_reg <= '0;
         pin_reg <= 1'b0;
      end else begin
         los_ctrl_reg <= los_ctrl_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= reg_read;
         link_prev_reg <= media_link_up;
         los_active_reg <= los_active_next;
         los_cnt_reg <= los_cnt_next;
         pin_reg <= pin_next;
      end
   end

   assign mgmt_rdata = rdata_reg;
   assign mgmt_rvalid = rvalid_reg;
   assign mgmt_active = smi_reg;
   assign clk_out_enable = clk_en_reg;
   assign pll_source_latched = strap_reg.pll_source_strap;
   assign module_mode = mode_reg;
   assign shared_los_pin = pin_reg;

endmodule // pslo_startup

// *** verification/pslo_sfp_host.sv ***
/* sfp host model: times every loss-of-signal pulse it receives.
   assumes the pin is sampled on core_clk and only counts in module mode. */
`timescale 1ns/1ns
module pslo_sfp_host (
   // clock, mode and pin
   input wire logic core_clk,
   input wire logic module_mode,
   input wire logic shared_los_pin,
   // results
   output logic [23:0] pulse_len = 24'h000000,
   output logic [7:0] pulse_cnt = 8'h00
);
   logic [23:0] run_len = 24'h000000;
   always @(posedge core_clk) begin
      if (module_mode && shared_los_pin) begin
         run_len <= run_len + 24'h000001;
      end else if (run_len != 24'h000000) begin
         pulse_len <= run_len;
         pulse_cnt <= pulse_cnt + 8'h01;
         run_len <= 24'h000000;
      end
   end
endmodule // pslo_sfp_host

// *** verification/pslo_startup_properties.sv ***
/* checker for pslo_startup: straps, startup timing, management reads and
   loss-of-signal pulses. bound to every pslo_startup instance. */
`timescale 1ns/1ns
module pslo_startup_properties #(
   parameter int unsigned REF = 20, CAL = 10, SH = 5, MD = 8, LG = 12
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // straps and status
   input wire logic pll_source_strap,
   input wire logic eeprom_data_strap,
   input wire logic module_mode_strap_bit,
   input wire logic media_link_up,
   input wire logic eeprom_script_done,
   // management
   input wire pslo_pkg::pslo_mgmt_req_t mgmt_req,
   input wire logic [15:0] mgmt_rdata,
   input wire logic mgmt_rvalid,
   // status and pin
   input wire logic mgmt_active,
   input wire logic clk_out_enable,
   input wire logic pll_source_latched,
   input wire logic module_mode,
   input wire logic shared_los_pin
);
   localparam int unsigned START = 1 + REF + 1000 + CAL;
   logic [15:0] reg_q, cyc;
   logic [23:0] hl;
   logic [1:0] pm;
   logic lk, dn;
   wire tk = mgmt_req.valid && mgmt_active;
   wire hit = mgmt_req.addr == pslo_pkg::LOS_CTRL_ADDR;
   wire wr = tk && mgmt_req.write && hit;
   wire [15:0] rx = hit ? reg_q : 16'h0000;
   // pulse length follows the mode in force at the edge that started it
   wire [23:0] n = pm == 2'h1 ? 24'(SH) : pm == 2'h2 ? 24'(MD) : 24'(LG);
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_q <= pslo_pkg::LOS_CTRL_RESET;
         cyc <= 16'h0000;
         hl <= 24'h000000;
         pm <= 2'h0;
         lk <= 1'b0;
         dn <= 1'b0;
      end else begin
         reg_q <= wr ? mgmt_req.wdata : reg_q;
         cyc <= cyc == 16'hFFFF ? cyc : cyc + 16'h0001;
         hl <= shared_los_pin ? hl + 24'h000001 : 24'h000000;
         pm <= shared_los_pin ? pm : reg_q[1:0];
         lk <= media_link_up;
         dn <= dn || (cyc != 16'h0000 && eeprom_script_done);
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_drop;
      module_mode && lk && !media_link_up && !shared_los_pin && reg_q[1:0] != 2'h0 && !wr;
   endsequence
   sequence s_read;
      tk && !mgmt_req.write;
   endsequence
   chk_strap_latch: assert property (cyc != 16'h0000 |->
      module_mode == !module_mode_strap_bit && pll_source_latched == pll_source_strap)
      else $error("strap latch wrong");
   chk_smi_early: assert property (cyc == 16'h0001 && !eeprom_data_strap |-> mgmt_active)
      else $error("management not active at first edge");
   chk_smi_hold: assert property (eeprom_data_strap && !dn |-> !mgmt_active)
      else $error("management active before script");
   chk_clk_start: assert property ($rose(clk_out_enable) |->
      cyc == 16'(START)) else $error("clock outputs start at wrong cycle");
   chk_clk_early: assert property (cyc < 16'(START) |-> !clk_out_enable)
      else $error("clock outputs before calibration");
   chk_los_rise: assert property (s_drop |=> shared_los_pin)
      else $error("no pulse on link drop");
   chk_pulse_end: assert property (module_mode && shared_los_pin &&
      hl == n - 24'h000001 |=> !shared_los_pin) else $error("pulse too long");
   chk_pulse_keep: assert property (module_mode && shared_los_pin &&
      hl < n - 24'h000001 && reg_q[1:0] != 2'h0 && !wr |=> shared_los_pin)
      else $error("pulse too short");
   chk_los_off: assert property (module_mode && reg_q[1:0] == 2'h0 ##1 reg_q[1:0] == 2'h0
      |-> !shared_los_pin) else $error("pin high in off mode");
   chk_read_data: assert property (s_read |=> mgmt_rvalid && mgmt_rdata == $past(rx))
      else $error("read answer wrong");
endmodule // pslo_startup_properties
bind pslo_startup pslo_startup_properties #(.REF(REF_SETTLE_CYCLES), .CAL(ADC_CAL_CYCLES),
   .SH(LOS_SHORT_CYCLES), .MD(LOS_MID_CYCLES), .LG(LOS_LONG_CYCLES)) pslo_chk (.*);

// *** verification/tb_pslo_startup.sv ***
/* testbench for pslo_startup: two resets, register access, pulses.
   assumes shortened counts; the host model times the pulses. */
`timescale 1ns/1ns
module tb_pslo_startup;
   logic core_clk = 1'b0, reset_n = 1'b0, pll_source_strap = 1'b0;
   logic eeprom_data_strap = 1'b0, module_mode_strap_bit = 1'b0;
   logic media_link_up = 1'b0, eeprom_script_done = 1'b0;
   pslo_pkg::pslo_mgmt_req_t mgmt_req = '0;
   logic [15:0] mgmt_rdata, d, cyc = 16'h0000;
   logic mgmt_rvalid, mgmt_active, clk_out_enable, pll_source_latched, module_mode;
   logic shared_los_pin, ans_valid;
   logic [15:0] ans_data;
   logic [23:0] pulse_len;
   logic [7:0] pulse_cnt, cnt0;
   logic [31:0] seed = 32'h0000002F;
   int fail_count = 0, tests_run = 0, i;
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= reset_n ? cyc + 16'h0001 : 16'h0000;
   pslo_startup #(.REF_SETTLE_CYCLES(20), .ADC_CAL_CYCLES(10), .LOS_SHORT_CYCLES(5),
      .LOS_MID_CYCLES(8), .LOS_LONG_CYCLES(12)) pslo_startup_inst (.*);
   pslo_sfp_host pslo_sfp_host_inst (.*);
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [31:0] plen(logic [1:0] m);
      return m == 2'h1 ? 32'h5 : m == 2'h2 ? 32'h8 : 32'hC;
   endfunction
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic acc(logic w, logic [4:0] a, logic [15:0] v);
      mgmt_req = '{1'b1, w, a, v};
      @(negedge core_clk);
      mgmt_req = '0;
      // answer is registered at the taking edge; an idle edge keeps requests apart
      ans_valid = mgmt_rvalid;
      ans_data = mgmt_rdata;
      @(negedge core_clk);
   endtask
   task automatic rd(logic [4:0] a, logic [15:0] e);
      acc(1'b0, a, 16'h0000);
      chk("read valid", ans_valid, 1'b1);
      chk("read data", ans_data, e);
   endtask
   task automatic rst(logic ee, logic mm);
      reset_n = 1'b0;
      eeprom_data_strap = ee;
      module_mode_strap_bit = mm;
      void'(rnd());
      pll_source_strap = seed[0];
      repeat (3) @(negedge core_clk);
      reset_n = 1'b1;
      @(negedge core_clk);
      chk("module mode", module_mode, !mm);
      chk("pll latch", pll_source_latched, pll_source_strap);
   endtask
   task automatic drop(logic [1:0] m);
      cnt0 = pulse_cnt;
      media_link_up = 1'b1;
      repeat (2) @(negedge core_clk);
      media_link_up = 1'b0;
      repeat (3) @(negedge core_clk);
      // a second drop inside the pulse must not stretch it
      media_link_up = 1'b1;
      @(negedge core_clk);
      media_link_up = 1'b0;
      repeat (16) @(negedge core_clk);
      chk("pulse count", pulse_cnt - cnt0, m != 2'h0);
      if (m != 2'h0) chk("pulse length", pulse_len, plen(m));
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      rst(1'b0, 1'b0);
      chk("smi early", mgmt_active, 1'b1);
      rd(5'h1E, pslo_pkg::LOS_CTRL_RESET);
      acc(1'b1, 5'h05, 16'hFFFF);
      rd(5'h05, 16'h0000);
      d = 16'(rnd());
      acc(1'b1, 5'h1E, d);
      rd(5'h1E, d);
      while (cyc != 16'h0406) @(negedge core_clk);
      chk("clock early", clk_out_enable, 1'b0);
      @(negedge core_clk);
      chk("clock on", clk_out_enable, 1'b1);
      for (i = 0; i < 4; i++) begin
         d = 16'(rnd());
         d[1:0] = i[1:0];
         acc(1'b1, 5'h1E, d);
         drop(i[1:0]);
      end
      rst(1'b1, 1'b1);
      acc(1'b0, 5'h1E, 16'h0000);
      chk("refused read", ans_valid, 1'b0);
      acc(1'b1, 5'h1E, 16'h0000);
      media_link_up = 1'b1;
      repeat (2) @(negedge core_clk);
      chk("signal detect", shared_los_pin, 1'b1);
      chk("smi held", mgmt_active, 1'b0);
      eeprom_script_done = 1'b1;
      @(negedge core_clk);
      eeprom_script_done = 1'b0;
      @(negedge core_clk);
      chk("smi after script", mgmt_active, 1'b1);
      rd(5'h1E, pslo_pkg::LOS_CTRL_RESET);
      final_report();
   end
   // the whole run needs about 1200 cycles
   initial begin
      repeat (4000) @(posedge core_clk);
      fail_count++;
      final_report();
   end
endmodule // tb_pslo_startup
